// ==== mailbox_regs.svh ====
// Register offsets, field positions and reset values of the host/DSP mailbox
`ifndef MAILBOX_REGS_SVH
`define MAILBOX_REGS_SVH

`define H2D_DATA_BASE 8'h00
`define H2D_GENERAL 8'h20
`define H2D_COMMAND 8'h24
`define H2D_BUSY 8'h28
`define D2H_DATA_BASE 8'h40
`define D2H_GENERAL 8'h60
`define D2H_COMMAND 8'h64
`define D2H_BUSY 8'h68
`define MAILBOX_CONFIG 8'h80
`define TX_BYTE_COUNT 8'h84
`define RX_BYTE_COUNT 8'h88
`define DMA_INT_STATUS_MASK 8'h8c
`define TX_BUF_BASE 8'ha0
`define RX_BUF_BASE 8'hc0

`define CFG_DMA_MODE_BIT 0
`define CFG_FLY_BY_BIT 1
`define CFG_RESET 2'h0

`define DISM_TX_DONE_BIT 0
`define DISM_RX_DONE_BIT 1
`define DISM_TX_EN_BIT 2
`define DISM_RX_EN_BIT 3
`define DISM_ALL_EN_BIT 4
`define DISM_RESET 5'h1c

`define COUNT_DONE 4'hf
`define DATA_RESET 16'h0000
`define COMMAND_RESET 8'h00

`endif

// ==== mailbox_pkg.sv ====
// Types shared by the host/DSP mailbox
package mailbox_pkg;

    // DMA-side pins, grouped so they travel through the synchroniser together
    typedef struct packed {
        logic ack_n;
        logic rd_n;
        logic wr_n;
        logic rw;
        logic ds_n;
        logic bus_mode;
        logic [7:0] din;
    } dma_pins_t;

    typedef struct packed {
        logic fly_by;
        logic dma_mode;
    } mb_cfg_t;

endpackage

// ==== dsp_host_mailbox.sv ====
// Host/DSP mailbox with DMA mailbox, APB register slave
//
// Behaviour
// R1: Host-to-DSP: eight data, general, command, busy.
// R2: Host writes data/command; DSP clears busy.
// R3: Host command write raises DSP command interrupt.
// R4: Command write sets busy; direct write clears.
// R5: Host polls busy zero before sending.
// R6: DSP command interrupt holds until command read.
// R7: Host waits for busy clear before new data.
// R8: DSP-to-host: eight data, general, command, busy.
// R9: DSP writes data/command; host clears busy.
// R10: DSP command write raises host interrupt.
// R11: DSP command write sets busy; host clears.
// R12: Host clears busy after executing command.
// R13: Config selects DMA or expanded mailbox mode.
// R14: DMA mailbox reached only by DMA controller. Code blocks only APB writes to tx_buf in DMA mode.
// R15: Separate transmit and receive request outputs.
// R16: Mode pin selects strobe set, ack qualified.
// R17: Config selects two-cycle or fly-by transfer.
// R18: Fly-by swaps read and write strobes.
// R19: Request high; low acknowledge is chip select.
// R20: Acknowledge high suspends; device waits.
// R21: Count-minus-one write starts the request.
// R22: End of transfer raises maskable DMA interrupt.
// R23: Reset clears flags, interrupts, requests, mode.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "mailbox_regs.svh"

module dsp_host_mailbox (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic dsp_command_interrupt,
    output logic host_interrupt,
    output logic dsp_dma_interrupt,
    output logic dma_request_transmit,
    output logic dma_request_receive,
    input wire logic dma_acknowledge_n,
    input wire logic dma_rd_n,
    input wire logic dma_wr_n,
    input wire logic dma_rw,
    input wire logic dma_ds_n,
    input wire logic bus_mode,
    input wire logic [7:0] dma_din,
    output logic [7:0] dma_dout,
    output logic dma_doe_n
);

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic hit_nxt;
    logic acc;
    logic wr_go;
    logic rd_go;
    logic [7:0] addr;

    logic [15:0] h2d_data_r [0:7];
    logic [15:0] d2h_data_r [0:7];
    logic [15:0] h2d_general_r;
    logic [15:0] d2h_general_r;
    logic [7:0] h2d_command_r;
    logic [7:0] d2h_command_r;
    logic h2d_busy_r;
    logic d2h_busy_r;
    logic dsp_cmd_int_r;
    logic host_int_r;
    mailbox_pkg::mb_cfg_t cfg_r;
    logic [4:0] dism_r;
    logic dma_int_r;

    mailbox_pkg::dma_pins_t s1_r;
    mailbox_pkg::dma_pins_t s2_r;
    mailbox_pkg::dma_pins_t s3_r;
    logic rd_cur;
    logic wr_cur;
    logic rd_prev;
    logic wr_prev;
    logic mb_wr_cur;
    logic mb_wr_prev;
    logic mb_rd_cur;
    logic mb_rd_prev;
    logic mb_wr_end;
    logic mb_rd_end;

    logic [7:0] tx_buf [0:15];
    logic [7:0] rx_buf [0:15];
    logic [3:0] tx_cnt_r;
    logic [3:0] rx_cnt_r;
    logic [3:0] tx_ptr_r;
    logic [3:0] rx_ptr_r;
    logic tx_act_r;
    logic rx_act_r;
    logic tx_done;
    logic rx_done;
    logic [7:0] dout_r;
    logic doe_n_r;

    assign addr = paddr[7:0];
    // Effect lands in the cycle the slave raises pready; one wait state
    assign acc = psel && penable && !pready_r;
    assign wr_go = acc && pwrite && hit_nxt;
    assign rd_go = acc && !pwrite && hit_nxt;

    // Register read mux and address decode
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt = (paddr[31:8] == 24'h00_0000);
        if (addr[7:5] == 3'h0) begin
            rdata_nxt = {16'h0000, h2d_data_r[addr[4:2]]};
        end else if (addr[7:5] == 3'h2) begin
            rdata_nxt = {16'h0000, d2h_data_r[addr[4:2]]};
        end else if (addr[7:5] == 3'h5) begin
            rdata_nxt = {16'h0000, tx_buf[{addr[4:2], 1'b1}], tx_buf[{addr[4:2], 1'b0}]};
        end else if (addr[7:5] == 3'h6) begin
            rdata_nxt = {16'h0000, rx_buf[{addr[4:2], 1'b1}], rx_buf[{addr[4:2], 1'b0}]};
        end else begin
            case (addr)
                `H2D_GENERAL: rdata_nxt = {16'h0000, h2d_general_r};
                `H2D_COMMAND: rdata_nxt = {24'h00_0000, h2d_command_r};
                `H2D_BUSY: rdata_nxt = {31'h0000_0000, h2d_busy_r};
                `D2H_GENERAL: rdata_nxt = {16'h0000, d2h_general_r};
                `D2H_COMMAND: rdata_nxt = {24'h00_0000, d2h_command_r};
                `D2H_BUSY: rdata_nxt = {31'h0000_0000, d2h_busy_r};
                `MAILBOX_CONFIG: rdata_nxt = {30'h0000_0000, cfg_r};
                `TX_BYTE_COUNT: rdata_nxt = {28'h000_0000, tx_cnt_r};
                `RX_BYTE_COUNT: rdata_nxt = {28'h000_0000, rx_cnt_r};
                `DMA_INT_STATUS_MASK: rdata_nxt = {27'h000_0000, dism_r};
                default: hit_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !hit_nxt;
            prdata_r <= (acc && !pwrite && hit_nxt) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // R1 R8 R2 R9 eight data words per direction
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_data
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    h2d_data_r[gi] <= `DATA_RESET;
                    d2h_data_r[gi] <= `DATA_RESET;
                end else begin
                    if (wr_go && addr == (`H2D_DATA_BASE + 8'(gi * 4))) begin
                        h2d_data_r[gi] <= pwdata[15:0];
                    end
                    if (wr_go && addr == (`D2H_DATA_BASE + 8'(gi * 4))) begin
                        d2h_data_r[gi] <= pwdata[15:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h2d_general_r <= `DATA_RESET;
            d2h_general_r <= `DATA_RESET;
            h2d_command_r <= `COMMAND_RESET;
            d2h_command_r <= `COMMAND_RESET;
        end else if (wr_go) begin
            if (addr == `H2D_GENERAL) h2d_general_r <= pwdata[15:0];
            if (addr == `D2H_GENERAL) d2h_general_r <= pwdata[15:0];
            if (addr == `H2D_COMMAND) h2d_command_r <= pwdata[7:0];
            if (addr == `D2H_COMMAND) d2h_command_r <= pwdata[7:0];
        end
    end

    // R3 R4 R6 R23 host-to-DSP busy and command interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h2d_busy_r <= 1'b0;
            dsp_cmd_int_r <= 1'b0;
        end else begin
            if (wr_go && addr == `H2D_COMMAND) begin
                h2d_busy_r <= 1'b1;
            end else if (wr_go && addr == `H2D_BUSY) begin
                h2d_busy_r <= 1'b0;
            end
            // A new command wins over the read that clears the last one
            if (wr_go && addr == `H2D_COMMAND) begin
                dsp_cmd_int_r <= 1'b1;
            end else if (rd_go && addr == `H2D_COMMAND) begin
                dsp_cmd_int_r <= 1'b0;
            end
        end
    end

    // R10 R11 R23 DSP-to-host busy and host interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d2h_busy_r <= 1'b0;
            host_int_r <= 1'b0;
        end else begin
            if (wr_go && addr == `D2H_COMMAND) begin
                d2h_busy_r <= 1'b1;
            end else if (wr_go && addr == `D2H_BUSY) begin
                d2h_busy_r <= 1'b0;
            end
            if (wr_go && addr == `D2H_COMMAND) begin
                host_int_r <= 1'b1;
            end else if (rd_go && addr == `D2H_COMMAND) begin
                host_int_r <= 1'b0;
            end
        end
    end

    // R13 R17 R23 mode selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= `CFG_RESET;
        end else if (wr_go && addr == `MAILBOX_CONFIG) begin
            cfg_r.dma_mode <= pwdata[`CFG_DMA_MODE_BIT];
            cfg_r.fly_by <= pwdata[`CFG_FLY_BY_BIT];
        end
    end

    // DMA pins are asynchronous to pclk; stages two and three give the edges, and the third stage the byte taken into tx_buf
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 14'h3e00;
            s2_r <= 14'h3e00;
            s3_r <= 14'h3e00;
        end else begin
            s1_r <= {dma_acknowledge_n, dma_rd_n, dma_wr_n, dma_rw, dma_ds_n, bus_mode, dma_din};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // R16 R19 strobe set chosen by the mode pin, qualified by acknowledge
    assign rd_cur = !s2_r.ack_n && (s2_r.bus_mode ? (s2_r.rw && !s2_r.ds_n) : !s2_r.rd_n);
    assign wr_cur = !s2_r.ack_n && (s2_r.bus_mode ? (!s2_r.rw && !s2_r.ds_n) : !s2_r.wr_n);
    assign rd_prev = !s3_r.ack_n && (s3_r.bus_mode ? (s3_r.rw && !s3_r.ds_n) : !s3_r.rd_n);
    assign wr_prev = !s3_r.ack_n && (s3_r.bus_mode ? (!s3_r.rw && !s3_r.ds_n) : !s3_r.wr_n);
    // R18 fly-by swaps the meaning of the strobes
    assign mb_wr_cur = cfg_r.fly_by ? rd_cur : wr_cur;
    assign mb_wr_prev = cfg_r.fly_by ? rd_prev : wr_prev;
    assign mb_rd_cur = cfg_r.fly_by ? wr_cur : rd_cur;
    assign mb_rd_prev = cfg_r.fly_by ? wr_prev : rd_prev;
    // Byte is taken at the end of the strobe, when bus data has settled
    assign mb_wr_end = mb_wr_prev && !mb_wr_cur;
    assign mb_rd_end = mb_rd_prev && !mb_rd_cur;
    assign tx_done = tx_act_r && mb_wr_end && tx_cnt_r == 4'h0;
    assign rx_done = rx_act_r && mb_rd_end && rx_cnt_r == 4'h0;

    // R21 R15 R20 transmit engine; stalls while acknowledge is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_r <= `COUNT_DONE;
            tx_ptr_r <= 4'h0;
            tx_act_r <= 1'b0;
        end else if (!cfg_r.dma_mode) begin
            tx_act_r <= 1'b0;
        end else if (wr_go && addr == `TX_BYTE_COUNT) begin
            tx_cnt_r <= pwdata[3:0];
            tx_ptr_r <= 4'h0;
            tx_act_r <= 1'b1;
        end else if (tx_act_r && mb_wr_end) begin
            tx_ptr_r <= tx_ptr_r + 4'h1;
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h0) begin
                tx_act_r <= 1'b0;
            end
        end
    end

    // R21 R15 R20 receive engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_r <= `COUNT_DONE;
            rx_ptr_r <= 4'h0;
            rx_act_r <= 1'b0;
        end else if (!cfg_r.dma_mode) begin
            rx_act_r <= 1'b0;
        end else if (wr_go && addr == `RX_BYTE_COUNT) begin
            rx_cnt_r <= pwdata[3:0];
            rx_ptr_r <= 4'h0;
            rx_act_r <= 1'b1;
        end else if (rx_act_r && mb_rd_end) begin
            rx_ptr_r <= rx_ptr_r + 4'h1;
            rx_cnt_r <= rx_cnt_r - 4'h1;
            if (rx_cnt_r == 4'h0) begin
                rx_act_r <= 1'b0;
            end
        end
    end

    // R14 buffers: DMA side only in DMA mode, bus side only in expanded mode for tx
    always_ff @(posedge pclk) begin
        if (tx_act_r && mb_wr_end) begin
            tx_buf[tx_ptr_r] <= s3_r.din;
        end else if (wr_go && !cfg_r.dma_mode && addr[7:5] == 3'h5) begin
            tx_buf[{addr[4:2], 1'b0}] <= pwdata[7:0];
            tx_buf[{addr[4:2], 1'b1}] <= pwdata[15:8];
        end
        if (wr_go && addr[7:5] == 3'h6) begin
            rx_buf[{addr[4:2], 1'b0}] <= pwdata[7:0];
            rx_buf[{addr[4:2], 1'b1}] <= pwdata[15:8];
        end
    end

    // R14 data bus driven only during an acknowledged mailbox read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_r <= 8'h00;
            doe_n_r <= 1'b1;
        end else begin
            dout_r <= rx_buf[rx_ptr_r];
            doe_n_r <= !(rx_act_r && mb_rd_cur);
        end
    end

    // R22 done flags set wins over write-one-clear; mask bits enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dism_r <= `DISM_RESET;
            dma_int_r <= 1'b0;
        end else begin
            if (wr_go && addr == `DMA_INT_STATUS_MASK) begin
                dism_r[4:2] <= pwdata[4:2];
                dism_r[1:0] <= dism_r[1:0] & ~pwdata[1:0];
            end
            if (tx_done) dism_r[`DISM_TX_DONE_BIT] <= 1'b1;
            if (rx_done) dism_r[`DISM_RX_DONE_BIT] <= 1'b1;
            dma_int_r <= dism_r[`DISM_ALL_EN_BIT]
                && ((dism_r[`DISM_TX_DONE_BIT] && dism_r[`DISM_TX_EN_BIT])
                || (dism_r[`DISM_RX_DONE_BIT] && dism_r[`DISM_RX_EN_BIT]));
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dsp_command_interrupt = dsp_cmd_int_r;
    assign host_interrupt = host_int_r;
    assign dsp_dma_interrupt = dma_int_r;
    assign dma_request_transmit = tx_act_r;
    assign dma_request_receive = rx_act_r;
    assign dma_dout = dout_r;
    assign dma_doe_n = doe_n_r;

    sequence seq_h2d_cmd_write;
        wr_go && addr == `H2D_COMMAND;
    endsequence

    sequence seq_d2h_cmd_write;
        wr_go && addr == `D2H_COMMAND;
    endsequence

    chk_h2d_cmd_effects: assert property (@(posedge pclk) disable iff (!presetn) // R3
        seq_h2d_cmd_write |=> h2d_busy_r && dsp_command_interrupt ##1 pready == 1'b0)
        else $error("host command did not set busy and interrupt");

    chk_h2d_busy_clear: assert property (@(posedge pclk) disable iff (!presetn) // R4
        wr_go && addr == `H2D_BUSY |=> !h2d_busy_r)
        else $error("busy write did not clear host-to-dsp busy");

    chk_cmd_int_hold: assert property (@(posedge pclk) disable iff (!presetn) // R6
        dsp_command_interrupt && !(rd_go && addr == `H2D_COMMAND) |=> dsp_command_interrupt)
        else $error("dsp command interrupt dropped without command read");

    chk_d2h_cmd_effects: assert property (@(posedge pclk) disable iff (!presetn) // R10
        seq_d2h_cmd_write |=> host_interrupt && d2h_busy_r)
        else $error("dsp command did not set host interrupt and busy");

    chk_count_starts_req: assert property (@(posedge pclk) disable iff (!presetn) // R21
        wr_go && addr == `TX_BYTE_COUNT && cfg_r.dma_mode
        |=> dma_request_transmit && tx_cnt_r == $past(pwdata[3:0]))
        else $error("count write did not raise transmit request");

    chk_tx_finish: assert property (@(posedge pclk) disable iff (!presetn) // R22
        tx_done && !(wr_go && addr == `TX_BYTE_COUNT)
        |=> !dma_request_transmit && tx_cnt_r == `COUNT_DONE && dism_r[`DISM_TX_DONE_BIT])
        else $error("transmit end not signalled");

    chk_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn) // R20
        s2_r.ack_n && s3_r.ack_n && !wr_go |=> $stable(tx_cnt_r) && $stable(rx_cnt_r))
        else $error("count moved while acknowledge high");

    chk_expanded_no_req: assert property (@(posedge pclk) disable iff (!presetn) // R13
        !cfg_r.dma_mode ##1 !cfg_r.dma_mode |-> !dma_request_transmit && !dma_request_receive)
        else $error("dma request in expanded mode");

endmodule

// ==== dma_ctrl_model.sv ====
// Behavioural external DMA controller driving the mailbox DMA pins
`timescale 1ns/1ps
module dma_ctrl_model (
    input wire logic pclk,
    input wire logic bus_mode,
    input wire logic fly_by,
    input wire logic [7:0] dma_dout,
    input wire logic dma_doe_n,
    output logic dma_acknowledge_n,
    output logic dma_rd_n,
    output logic dma_wr_n,
    output logic dma_rw,
    output logic dma_ds_n,
    output logic [7:0] dma_din
);
    logic drv;
    logic [7:0] wdat;
    initial begin
        dma_acknowledge_n = 1'b1;
        dma_rd_n = 1'b1;
        dma_wr_n = 1'b1;
        dma_rw = 1'b1;
        dma_ds_n = 1'b1;
        dma_din = 8'h00;
        drv = 1'b0;
        wdat = 8'h00;
    end
    // Undriven bus keeps changing so a stale byte never looks valid
    always @(posedge pclk) begin
        dma_din <= drv ? wdat : ~dma_din;
    end
    task automatic xfer(input logic dev_wr, input logic [7:0] wb, output logic [7:0] rb);
        logic wstb;
        wstb = dev_wr ^ fly_by;
        @(posedge pclk);
        drv = dev_wr;
        wdat = wb;
        dma_acknowledge_n <= 1'b0;
        dma_rw <= ~wstb;
        repeat (3) @(posedge pclk);
        if (bus_mode) begin
            dma_ds_n <= 1'b0;
        end else if (wstb) begin
            dma_wr_n <= 1'b0;
        end else begin
            dma_rd_n <= 1'b0;
        end
        repeat (6) @(posedge pclk);
        // Released bus shows the inverse, so a missing drive enable fails the compare
        rb = dma_doe_n ? ~dma_dout : dma_dout;
        dma_ds_n <= 1'b1;
        dma_wr_n <= 1'b1;
        dma_rd_n <= 1'b1;
        repeat (4) @(posedge pclk);
        drv = 1'b0;
    endtask
    task automatic hold_off(input int n);
        @(posedge pclk);
        dma_acknowledge_n <= 1'b1;
        repeat (n) @(posedge pclk);
    endtask
endmodule

// ==== dsp_host_mailbox_tb.sv ====
// Self-checking bench for the host/DSP mailbox over APB and the DMA pins
`timescale 1ns/1ps
`include "mailbox_regs.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module dsp_host_mailbox_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic dsp_command_interrupt, host_interrupt, dsp_dma_interrupt;
    logic dma_request_transmit, dma_request_receive, dma_acknowledge_n;
    logic dma_rd_n, dma_wr_n, dma_rw, dma_ds_n, bus_mode, fly_by, dma_doe_n;
    logic [7:0] dma_din, dma_dout, rb, offs;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    dsp_host_mailbox uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .dsp_command_interrupt, .host_interrupt,
        .dsp_dma_interrupt, .dma_request_transmit, .dma_request_receive,
        .dma_acknowledge_n, .dma_rd_n, .dma_wr_n, .dma_rw, .dma_ds_n, .bus_mode,
        .dma_din, .dma_dout, .dma_doe_n);
    dma_ctrl_model dma (.pclk, .bus_mode, .fly_by, .dma_dout, .dma_doe_n, .dma_acknowledge_n,
        .dma_rd_n, .dma_wr_n, .dma_rw, .dma_ds_n, .dma_din);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out;
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rd)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        bus_mode = 1'b0;
        fly_by = 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("doe_n", 1'b1, dma_doe_n)
        presetn <= 1'b1;
        rchk(`H2D_BUSY, 32'h0);
        rchk(`D2H_BUSY, 32'h0);
        rchk(`MAILBOX_CONFIG, {30'h0, `CFG_RESET});
        rchk(`DMA_INT_STATUS_MASK, {27'h0, `DISM_RESET});
        `CHK("req", 2'b00, {dma_request_transmit, dma_request_receive})
        for (int d = 0; d < 2; d++) begin
            offs = (d == 1) ? `D2H_DATA_BASE : `H2D_DATA_BASE;
            rchk(`H2D_BUSY + offs, 32'h0);
            for (int i = 0; i < 8; i++) begin
                apb(1'b1, `H2D_DATA_BASE + offs + 8'(4 * i), {16'hdead, 16'h1111 * 16'(i)});
            end
            apb(1'b1, `H2D_GENERAL + offs, 32'hffffa5a5);
            rchk(`H2D_BUSY + offs, 32'h0);
            apb(1'b1, `H2D_COMMAND + offs, 32'h123456aa);
            `CHK("cmd irq", 1'b1, d ? host_interrupt : dsp_command_interrupt)
            rchk(`H2D_BUSY + offs, 32'h1);
            for (int i = 0; i < 8; i++) begin
                rchk(`H2D_DATA_BASE + offs + 8'(4 * i), {16'h0, 16'h1111 * 16'(i)});
            end
            rchk(`H2D_GENERAL + offs, 32'h0000a5a5);
            `CHK("cmd irq", 1'b1, d ? host_interrupt : dsp_command_interrupt)
            rchk(`H2D_COMMAND + offs, 32'h000000aa);
            `CHK("cmd irq", 1'b0, d ? host_interrupt : dsp_command_interrupt)
            apb(1'b1, `H2D_BUSY + offs, 32'h1);
            rchk(`H2D_BUSY + offs, 32'h0);
        end
        rchk(8'h2c, 32'h0);
        `CHK("slverr", 1'b1, last_err)
        apb(1'b1, `TX_BYTE_COUNT, 32'h0);
        tick(4);
        `CHK("tx req", 1'b0, dma_request_transmit)
        apb(1'b1, `MAILBOX_CONFIG, 32'h1);
        rchk(`MAILBOX_CONFIG, 32'h1);
        apb(1'b1, `TX_BYTE_COUNT, 32'h1);
        tick(2);
        `CHK("req", 2'b10, {dma_request_transmit, dma_request_receive})
        dma.xfer(1'b1, 8'h3c, rb);
        dma.hold_off(8);
        `CHK("tx req", 1'b1, dma_request_transmit)
        rchk(`TX_BYTE_COUNT, 32'h0);
        dma.xfer(1'b1, 8'hc3, rb);
        dma.hold_off(8);
        `CHK("tx req", 1'b0, dma_request_transmit)
        `CHK("dma irq", 1'b1, dsp_dma_interrupt)
        rchk(`TX_BUF_BASE, 32'h0000c33c);
        apb(1'b1, `TX_BUF_BASE, 32'h00001234);
        rchk(`TX_BUF_BASE, 32'h0000c33c);
        rchk(`DMA_INT_STATUS_MASK, 32'h1d);
        apb(1'b1, `DMA_INT_STATUS_MASK, 32'h18);
        tick(2);
        `CHK("dma irq", 1'b0, dsp_dma_interrupt)
        // Done flags cleared and the whole interrupt masked for the receive pass
        apb(1'b1, `DMA_INT_STATUS_MASK, 32'h0f);
        bus_mode <= 1'b1;
        apb(1'b1, `RX_BUF_BASE, 32'h0000beef);
        apb(1'b1, `RX_BYTE_COUNT, 32'h1);
        tick(2);
        `CHK("req", 2'b01, {dma_request_transmit, dma_request_receive})
        dma.xfer(1'b0, 8'h00, rb);
        `CHK("rx byte", 8'hef, rb)
        dma.xfer(1'b0, 8'h00, rb);
        `CHK("rx byte", 8'hbe, rb)
        dma.hold_off(8);
        `CHK("rx req", 1'b0, dma_request_receive)
        `CHK("dma irq", 1'b0, dsp_dma_interrupt)
        apb(1'b1, `DMA_INT_STATUS_MASK, 32'h1c);
        tick(2);
        `CHK("dma irq", 1'b1, dsp_dma_interrupt)
        apb(1'b1, `DMA_INT_STATUS_MASK, 32'h1f);
        apb(1'b1, `MAILBOX_CONFIG, 32'h3);
        fly_by <= 1'b1;
        bus_mode <= 1'b0;
        apb(1'b1, `TX_BYTE_COUNT, 32'h0);
        dma.xfer(1'b1, 8'h77, rb);
        dma.hold_off(8);
        `CHK("tx req", 1'b0, dma_request_transmit)
        apb(1'b0, `TX_BUF_BASE, 32'h0);
        `CHK("fly byte", 8'h77, rd[7:0])
        apb(1'b1, `RX_BUF_BASE, 32'h00000069);
        apb(1'b1, `RX_BYTE_COUNT, 32'h0);
        dma.xfer(1'b0, 8'h00, rb);
        `CHK("fly rx byte", 8'h69, rb)
        dma.hold_off(8);
        `CHK("rx req", 1'b0, dma_request_receive)
        `CHK("doe_n", 1'b1, dma_doe_n)
        apb(1'b1, `H2D_COMMAND, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`H2D_BUSY, 32'h0);
        rchk(`MAILBOX_CONFIG, 32'h0);
        `CHK("cmd irq", 1'b0, dsp_command_interrupt)
        close_out;
    end
endmodule
